// ---- core/slcd_engine.sv ----
// Function
// (RULE_01) bytes 40-5F store the five-bit mode: multiplex, bias, frame rate
// (RULE_02) 30 copies display ram to latch while chip select is inactive
// (RULE_03) 31 copies display ram to latch on each drive frame
// (RULE_04) 38 stops copying display ram into the latch
// (RULE_05) bytes E0-FF load the low five bits into the pointer
// (RULE_06) 20 zeroes the display ram and the pointer
// (RULE_07) D0-DF write the nibble to display ram, pointer advances
// (RULE_08) 90-9F and the nibble into display ram, pointer advances
// (RULE_09) B0-BF or the nibble into display ram, pointer advances
// (RULE_10) 15 enables the segment decoder, 14 disables it
// (RULE_11) 11 turns the lcd on, 10 turns it off
// (RULE_12) 00 zeroes the blink ram and the pointer
// (RULE_13) C0-CF write the nibble to blink ram, pointer advances
// (RULE_14) 80-8F and the nibble into blink ram, pointer advances
// (RULE_15) A0-AF or the nibble into blink ram, pointer advances
// (RULE_16) 1A/1B start blinking, bit 0 picks rate; 18 stops it
// (RULE_17) decoded numeric 00-0F gives three or two nibbles by multiplex
// (RULE_18) decoded alphanumeric A0-DF gives four nibbles; invalid codes skipped
// (RULE_19) eight serial bits per byte, clocked by the host serial clock
// (RULE_20) the command/data line marks each byte as command or data
// (RULE_21) busy output shows when the next byte may be sent
// (RULE_22) with chip select inactive the display may update from ram
// (RULE_23) decoded nibbles advance the pointer; unknown commands are ignored
// (RULE_24) 32 nibbles per ram, five-bit pointer wraps to zero
`timescale 1ns/1ps
`default_nettype none
`include "slcd_params.svh"

module slcd_engine #(
    parameter int unsigned DEPTH = `SLCD_RAM_DEPTH,
    parameter int unsigned AW = `SLCD_PTR_W
) (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic i_sck,
    input wire logic i_si,
    input wire logic i_cs_n,
    input wire logic i_cmd_data,
    input wire logic i_frame_tick,
    output logic o_busy_n,
    output var slcd_pkg::slcd_cfg_t o_cfg,
    output logic [AW-1:0] o_data_ptr,
    output logic [4*DEPTH-1:0] o_disp_latch,
    output logic [4*DEPTH-1:0] o_blink_ram
);

    // serial clock domain
    logic [6:0] shift;
    logic [2:0] bit_cnt;
    logic link_tog;
    slcd_pkg::slcd_rx_t link_hold;

    // chip select high clears the bit count, so a torn byte never lands
    always_ff @(posedge i_sck or posedge i_cs_n or posedge i_srst) begin
        if (i_cs_n || i_srst) begin
            bit_cnt <= 3'h0;
        end else begin
            bit_cnt <= bit_cnt + 3'h1; // [RULE_19]
        end
    end

    always_ff @(posedge i_sck) begin
        shift <= {shift[5:0], i_si}; // [RULE_19]
    end

    // held byte stays still until the next eighth edge; the host waits
    // on busy before sending it, so the system side reads it quietly
    always_ff @(posedge i_sck or posedge i_srst) begin
        if (i_srst) begin
            link_tog <= 1'b0;
            link_hold <= '0;
        end else if (!i_cs_n && bit_cnt == 3'h7) begin
            link_hold.data <= {shift, i_si}; // [RULE_19]
            link_hold.cmd <= i_cmd_data; // [RULE_20]
            link_tog <= ~link_tog;
        end
    end

    // system clock domain: synchronisers
    logic tog_s1;
    logic tog_s2;
    logic cs_s1;
    logic cs_s2;
    logic tog_seen;

    always_ff @(posedge i_sys_clk) begin
        tog_s1 <= link_tog;
        tog_s2 <= tog_s1;
        cs_s1 <= i_cs_n;
        cs_s2 <= cs_s1;
    end

    slcd_pkg::slcd_state_t state;
    logic pending;
    logic rx_go;
    slcd_pkg::slcd_rx_t rx;

    assign pending = (tog_s2 != tog_seen);
    assign rx_go = pending && (state == slcd_pkg::SLCD_ST_IDLE);
    assign rx = link_hold;

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            tog_seen <= tog_s2;
        end else if (rx_go) begin
            tog_seen <= tog_s2;
        end
    end

    // decoder tables
    function automatic logic [19:0] num_tab(input logic [3:0] c);
        logic [19:0] v;
        v = 20'h00000;
        case (c)
            4'h0: v = 20'h353d7;
            4'h1: v = 20'h00306;
            4'h2: v = 20'h271e3;
            4'h3: v = 20'h073a7;
            4'h4: v = 20'h12336;
            4'h5: v = 20'h172b5;
            4'h6: v = 20'h372f5;
            4'h7: v = 20'h01307;
            4'h8: v = 20'h373f7;
            4'h9: v = 20'h173b7;
            4'ha: v = 20'h32020;
            4'hb: v = 20'h370f1;
            4'hc: v = 20'h350d1;
            4'hd: v = 20'h060a0;
            4'he: v = 20'h262e4;
            default: v = 20'h00000;
        endcase
        return v;
    endfunction : num_tab

    // bit 16 marks a valid code; nibble for address n sits lowest
    function automatic logic [16:0] alnum_tab(input logic [5:0] c);
        logic [16:0] v;
        v = 17'h00000;
        case (c)
            6'h00: v = 17'h10000;
            6'h07: v = 17'h10002;
            6'h08: v = 17'h1000a;
            6'h09: v = 17'h15000;
            6'h0a: v = 17'h1f00f;
            6'h0b: v = 17'h1a005;
            6'h0d: v = 17'h12004;
            6'h0f: v = 17'h14002;
            6'h10: v = 17'h147e2;
            6'h11: v = 17'h10600;
            6'h12: v = 17'h123c4;
            6'h13: v = 17'h12784;
            6'h14: v = 17'h12624;
            6'h15: v = 17'h125a4;
            6'h16: v = 17'h125e4;
            6'h17: v = 17'h10700;
            6'h18: v = 17'h127e4;
            6'h19: v = 17'h127a4;
            6'h1c: v = 17'h14082;
            6'h1d: v = 17'h12084;
            6'h1e: v = 17'h11088;
            6'h20: v = 17'h1a7c0;
            6'h21: v = 17'h12764;
            6'h22: v = 17'h18785;
            6'h23: v = 17'h101e0;
            6'h24: v = 17'h18781;
            6'h25: v = 17'h121e4;
            6'h26: v = 17'h12164;
            6'h27: v = 17'h105e4;
            6'h28: v = 17'h12664;
            6'h29: v = 17'h18181;
            6'h2a: v = 17'h106c0;
            6'h2b: v = 17'h1206a;
            6'h2c: v = 17'h100e0;
            6'h2d: v = 17'h11662;
            6'h2e: v = 17'h11668;
            6'h2f: v = 17'h107e0;
            6'h30: v = 17'h12364;
            6'h31: v = 17'h107e8;
            6'h32: v = 17'h1236c;
            6'h33: v = 17'h11584;
            6'h34: v = 17'h18101;
            6'h35: v = 17'h106e0;
            6'h36: v = 17'h14062;
            6'h37: v = 17'h14668;
            6'h38: v = 17'h1500a;
            6'h39: v = 17'h19002;
            6'h3a: v = 17'h14182;
            6'h3c: v = 17'h11008;
            default: v = 17'h00000;
        endcase
        return v;
    endfunction : alnum_tab

    // storage
    logic [3:0] disp_ram [DEPTH];
    logic [3:0] blink_ram [DEPTH];
    logic [3:0] latch [DEPTH];
    logic [AW-1:0] ptr;
    slcd_pkg::slcd_cfg_t cfg;
    logic [15:0] dec_shift;
    logic [2:0] dec_left;

    // decoder lookup for the byte at hand
    logic [19:0] num_v;
    logic [16:0] aln_v;
    logic [5:0] aln_idx;
    logic is_num;
    logic is_aln;
    logic quad;

    assign aln_idx = 6'(rx.data - `SLCD_ALNUM_MIN);
    assign num_v = num_tab(rx.data[3:0]);
    assign aln_v = alnum_tab(aln_idx);
    assign quad = (cfg.mode[`SLCD_MUX_LSB+:2] == `SLCD_MUX_QUAD);
    assign is_num = (rx.data <= `SLCD_NUM_MAX);
    assign is_aln = (rx.data >= `SLCD_ALNUM_MIN)
        && (rx.data <= `SLCD_ALNUM_MAX) && aln_v[16]; // [RULE_18]

    // one ram operation per cycle, at the pointer except the whole-ram clears
    logic disp_we;
    logic blink_we;
    logic [3:0] wdat;
    logic ptr_step;
    logic clr_disp;
    logic clr_blink;
    logic [3:0] old_d;
    logic [3:0] old_b;

    always_comb begin
        disp_we = 1'b0;
        blink_we = 1'b0;
        wdat = rx.data[3:0];
        ptr_step = 1'b0;
        clr_disp = 1'b0;
        clr_blink = 1'b0;
        old_d = disp_ram[ptr];
        old_b = blink_ram[ptr];
        if (state == slcd_pkg::SLCD_ST_DEC) begin
            disp_we = 1'b1; // [RULE_23]
            wdat = dec_shift[3:0];
            ptr_step = 1'b1;
        end else if (rx_go && rx.cmd) begin
            casez (rx.data)
                `SLCD_CMD_CLR_DISP: clr_disp = 1'b1; // [RULE_06]
                `SLCD_CMD_CLR_BLINK: clr_blink = 1'b1; // [RULE_12]
                `SLCD_CMD_WR_DISP: begin
                    disp_we = 1'b1; // [RULE_07]
                    ptr_step = 1'b1;
                end
                `SLCD_CMD_AND_DISP: begin
                    disp_we = 1'b1;
                    wdat = old_d & rx.data[3:0]; // [RULE_08]
                    ptr_step = 1'b1;
                end
                `SLCD_CMD_OR_DISP: begin
                    disp_we = 1'b1;
                    wdat = old_d | rx.data[3:0]; // [RULE_09]
                    ptr_step = 1'b1;
                end
                `SLCD_CMD_WR_BLINK: begin
                    blink_we = 1'b1; // [RULE_13]
                    ptr_step = 1'b1;
                end
                `SLCD_CMD_AND_BLINK: begin
                    blink_we = 1'b1;
                    wdat = old_b & rx.data[3:0]; // [RULE_14]
                    ptr_step = 1'b1;
                end
                `SLCD_CMD_OR_BLINK: begin
                    blink_we = 1'b1;
                    wdat = old_b | rx.data[3:0]; // [RULE_15]
                    ptr_step = 1'b1;
                end
                default: ptr_step = 1'b0; // [RULE_23]
            endcase
        end
    end

    // pointer wraps naturally at its width
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            ptr <= `SLCD_RST_PTR;
        end else if (clr_disp || clr_blink) begin
            ptr <= `SLCD_RST_PTR; // [RULE_06] [RULE_12]
        end else if (ptr_step) begin
            ptr <= ptr + AW'(1); // [RULE_24]
        end else if (rx_go && rx.cmd && rx.data[7:5] == 3'h7) begin
            ptr <= rx.data[AW-1:0]; // [RULE_05]
        end
    end

    // configuration commands
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            cfg.mode <= `SLCD_RST_MODE;
            cfg.xfer <= slcd_pkg::SLCD_XFER_CS;
            cfg.display_on <= 1'b0;
            cfg.decoder_on <= 1'b0;
            cfg.blink_on <= 1'b0;
            cfg.blink_rate <= 1'b0;
        end else if (rx_go && rx.cmd) begin
            casez (rx.data)
                `SLCD_CMD_MODE_LO,
                `SLCD_CMD_MODE_HI: cfg.mode <= rx.data[4:0]; // [RULE_01]
                `SLCD_CMD_XFER_CS:
                    cfg.xfer <= slcd_pkg::SLCD_XFER_CS; // [RULE_02]
                `SLCD_CMD_XFER_FRAME:
                    cfg.xfer <= slcd_pkg::SLCD_XFER_FRAME; // [RULE_03]
                `SLCD_CMD_XFER_HOLD:
                    cfg.xfer <= slcd_pkg::SLCD_XFER_HOLD; // [RULE_04]
                `SLCD_CMD_DEC_ON: cfg.decoder_on <= 1'b1; // [RULE_10]
                `SLCD_CMD_DEC_OFF: cfg.decoder_on <= 1'b0; // [RULE_10]
                `SLCD_CMD_LCD_ON: cfg.display_on <= 1'b1; // [RULE_11]
                `SLCD_CMD_LCD_OFF: cfg.display_on <= 1'b0; // [RULE_11]
                `SLCD_CMD_BLINK_ON0,
                `SLCD_CMD_BLINK_ON1: begin
                    cfg.blink_on <= 1'b1; // [RULE_16]
                    cfg.blink_rate <= rx.data[0];
                end
                `SLCD_CMD_BLINK_OFF: cfg.blink_on <= 1'b0; // [RULE_16]
                default: cfg.blink_on <= cfg.blink_on; // [RULE_23]
            endcase
        end
    end

    // decoder sequencer: one nibble per cycle, lowest address first
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            state <= slcd_pkg::SLCD_ST_IDLE;
            dec_shift <= 16'h0000;
            dec_left <= 3'h0;
        end else begin
            case (state)
                slcd_pkg::SLCD_ST_IDLE: begin
                    if (rx_go && !rx.cmd && cfg.decoder_on) begin
                        if (is_num) begin
                            state <= slcd_pkg::SLCD_ST_DEC; // [RULE_17]
                            if (quad) begin
                                dec_shift <= {8'h00, num_v[7:0]};
                                dec_left <= `SLCD_NIBS_QUAD;
                            end else begin
                                dec_shift <= {4'h0, num_v[19:8]};
                                dec_left <= `SLCD_NIBS_TRI;
                            end
                        end else if (is_aln) begin
                            state <= slcd_pkg::SLCD_ST_DEC; // [RULE_18]
                            dec_shift <= aln_v[15:0];
                            dec_left <= `SLCD_NIBS_ALNUM;
                        end
                    end
                end
                slcd_pkg::SLCD_ST_DEC: begin
                    dec_shift <= {4'h0, dec_shift[15:4]};
                    dec_left <= dec_left - 3'h1;
                    if (dec_left == 3'h1) begin
                        state <= slcd_pkg::SLCD_ST_IDLE;
                    end
                end
                default: state <= slcd_pkg::SLCD_ST_IDLE;
            endcase
        end
    end

    // ram entries and latch, one slice per location
    logic copy;
    assign copy = (cfg.xfer == slcd_pkg::SLCD_XFER_CS && cs_s2)
        || (cfg.xfer == slcd_pkg::SLCD_XFER_FRAME && i_frame_tick);

    for (genvar i = 0; i < DEPTH; i++) begin : g_loc
        always_ff @(posedge i_sys_clk) begin
            if (i_srst || clr_disp) begin
                disp_ram[i] <= 4'h0; // [RULE_06]
            end else if (disp_we && ptr == AW'(i)) begin
                disp_ram[i] <= wdat;
            end
        end
        always_ff @(posedge i_sys_clk) begin
            if (i_srst || clr_blink) begin
                blink_ram[i] <= 4'h0; // [RULE_12]
            end else if (blink_we && ptr == AW'(i)) begin
                blink_ram[i] <= wdat;
            end
        end
        // the cs-timed copy only runs while the host is away
        always_ff @(posedge i_sys_clk) begin
            if (i_srst) begin
                latch[i] <= 4'h0;
            end else if (copy) begin
                latch[i] <= disp_ram[i]; // [RULE_02] [RULE_03] [RULE_22]
            end
        end
        assign o_disp_latch[4*i+:4] = latch[i];
        assign o_blink_ram[4*i+:4] = blink_ram[i];
    end

    // busy low from seeing a byte until its work is done
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_busy_n <= 1'b1;
        end else begin
            o_busy_n <= !(pending
                || state == slcd_pkg::SLCD_ST_DEC
                || (rx_go && !rx.cmd && cfg.decoder_on
                    && (is_num || is_aln))); // [RULE_21]
        end
    end

    assign o_cfg = cfg;
    assign o_data_ptr = ptr;

endmodule : slcd_engine

`default_nettype wire

// ---- core/slcd_params.svh ----
`ifndef SLCD_PARAMS_SVH
`define SLCD_PARAMS_SVH

// ram geometry
`define SLCD_RAM_DEPTH 32
`define SLCD_PTR_W 5
`define SLCD_NIB_W 4

// command codes, casez patterns use ? for immediate fields
`define SLCD_CMD_MODE_LO 8'h4?
`define SLCD_CMD_MODE_HI 8'h5?
`define SLCD_CMD_XFER_CS 8'h30
`define SLCD_CMD_XFER_FRAME 8'h31
`define SLCD_CMD_XFER_HOLD 8'h38
`define SLCD_CMD_PTR_LO 8'he?
`define SLCD_CMD_PTR_HI 8'hf?
`define SLCD_CMD_CLR_DISP 8'h20
`define SLCD_CMD_WR_DISP 8'hd?
`define SLCD_CMD_AND_DISP 8'h9?
`define SLCD_CMD_OR_DISP 8'hb?
`define SLCD_CMD_DEC_ON 8'h15
`define SLCD_CMD_DEC_OFF 8'h14
`define SLCD_CMD_LCD_ON 8'h11
`define SLCD_CMD_LCD_OFF 8'h10
`define SLCD_CMD_CLR_BLINK 8'h00
`define SLCD_CMD_WR_BLINK 8'hc?
`define SLCD_CMD_AND_BLINK 8'h8?
`define SLCD_CMD_OR_BLINK 8'ha?
`define SLCD_CMD_BLINK_ON0 8'h1a
`define SLCD_CMD_BLINK_ON1 8'h1b
`define SLCD_CMD_BLINK_OFF 8'h18

// mode field layout: low two bits pick the multiplexing
`define SLCD_MUX_LSB 0
`define SLCD_MUX_QUAD 2'h3

// decoder byte ranges
`define SLCD_NUM_MAX 8'h0f
`define SLCD_ALNUM_MIN 8'ha0
`define SLCD_ALNUM_MAX 8'hdf
`define SLCD_NIBS_TRI 3'h3
`define SLCD_NIBS_QUAD 3'h2
`define SLCD_NIBS_ALNUM 3'h4

// reset values
`define SLCD_RST_MODE 5'h00
`define SLCD_RST_PTR 5'h00

`endif

// ---- core/slcd_pkg.sv ----
`default_nettype none
package slcd_pkg;

    typedef enum logic [1:0] {
        SLCD_XFER_CS,
        SLCD_XFER_FRAME,
        SLCD_XFER_HOLD
    } slcd_xfer_t;

    typedef enum logic {
        SLCD_ST_IDLE,
        SLCD_ST_DEC
    } slcd_state_t;

    typedef struct packed {
        logic [4:0] mode;
        slcd_xfer_t xfer;
        logic display_on;
        logic decoder_on;
        logic blink_on;
        logic blink_rate;
    } slcd_cfg_t;

    typedef struct packed {
        logic cmd;
        logic [7:0] data;
    } slcd_rx_t;

endpackage : slcd_pkg
`default_nettype wire

// ---- tb/slcd_engine_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module slcd_engine_checker #(
    parameter int unsigned DEPTH = 32,
    parameter int unsigned AW = 5
) (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic i_cs_n,
    input wire logic i_frame_tick,
    input wire logic o_busy_n,
    input wire slcd_pkg::slcd_cfg_t o_cfg,
    input wire logic [AW-1:0] o_data_ptr,
    input wire logic [4*DEPTH-1:0] o_disp_latch,
    input wire logic [4*DEPTH-1:0] o_blink_ram
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    reset_state_a: assert property (disable iff (1'b0)
        i_srst |=> o_busy_n && o_data_ptr == '0 && o_cfg == '0
            && o_blink_ram == '0 && o_disp_latch == '0
    ) else $error("state not cleared by reset");
    // commands take one cycle, decoded data at most four more
    busy_len_a: assert property (
        $fell(o_busy_n) |-> ##[1:5] o_busy_n
    ) else $error("busy held too long");
    ptr_quiet_a: assert property (
        !$stable(o_data_ptr) && !$past(i_srst)
            |-> !o_busy_n || !$past(o_busy_n)
    ) else $error("pointer moved with no byte executing");
    blink_quiet_a: assert property (
        !$stable(o_blink_ram) && !$past(i_srst)
            |-> !o_busy_n || !$past(o_busy_n)
    ) else $error("blink ram moved with no byte executing");
    cfg_quiet_a: assert property (
        !$stable(o_cfg) && !$past(i_srst)
            |-> !o_busy_n || !$past(o_busy_n)
    ) else $error("config moved with no byte executing");
    hold_latch_a: assert property (
        $past(o_cfg.xfer) == slcd_pkg::SLCD_XFER_HOLD
            && $past(o_cfg.xfer, 2) == slcd_pkg::SLCD_XFER_HOLD
            |-> $stable(o_disp_latch)
    ) else $error("latch copied while suspended");
    frame_latch_a: assert property (
        $past(o_cfg.xfer) == slcd_pkg::SLCD_XFER_FRAME
            && $past(o_cfg.xfer, 2) == slcd_pkg::SLCD_XFER_FRAME
            && !$past(i_frame_tick) && !$past(i_frame_tick, 2)
            && !$past(i_frame_tick, 3) |-> $stable(o_disp_latch)
    ) else $error("latch copied with no frame tick");
    cs_idle_a: assert property (
        (i_cs_n && o_busy_n) [*8] |=> o_busy_n
    ) else $error("busy with chip select idle");
    cover property ($fell(o_busy_n));
    cover property (!o_busy_n [*4]);
    cover property (o_cfg.xfer == slcd_pkg::SLCD_XFER_FRAME && i_frame_tick);
endmodule : slcd_engine_checker
`default_nettype wire

// ---- tb/slcd_engine_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module slcd_engine_tb_top;
    typedef struct packed {
        logic [4:0] p;
        slcd_pkg::slcd_cfg_t c;
        logic [127:0] b;
        logic [127:0] l;
    } slcd_note_t;
    logic i_sys_clk, i_srst, i_frame_tick, sck, si, cs_n, cd, busy_n;
    slcd_pkg::slcd_cfg_t cfg, c;
    logic [4:0] ptr, p;
    logic [127:0] lat_o, blk_o, lat;
    logic [3:0] dr [32];
    logic [3:0] br [32];
    slcd_note_t q [$];
    int bad_count, samples_checked;
    logic [11:0] num3 [16] = '{12'h353, 12'h003, 12'h271, 12'h073,
        12'h123, 12'h172, 12'h372, 12'h013, 12'h373, 12'h173, 12'h320,
        12'h370, 12'h350, 12'h060, 12'h262, 12'h000};
    logic [7:0] num2 [16] = '{8'hd7, 8'h06, 8'he3, 8'ha7, 8'h36, 8'hb5,
        8'hf5, 8'h07, 8'hf7, 8'hb7, 8'h20, 8'hf1, 8'hd1, 8'ha0, 8'he4, 8'h00};
    logic [7:0] cfgs [12] = '{8'h11, 8'h10, 8'h15, 8'h14, 8'h1b, 8'h1a,
        8'h18, 8'h41, 8'h5f, 8'h12, 8'h60, 8'h3f};
    logic [7:0] ramops [14] = '{8'hff, 8'hd5, 8'hd6, 8'he0, 8'h93, 8'hbc,
        8'hff, 8'hca, 8'hc3, 8'hff, 8'h86, 8'ha9, 8'h20, 8'h00};
    logic [7:0] ops6 [6] = '{8'hd0, 8'h90, 8'hb0, 8'hc0, 8'h80, 8'ha0};
    logic [7:0] alnum [8] = '{8'ha0, 8'hb0, 8'hc0, 8'ha7, 8'ha1, 8'hdf, 8'h50,
        8'hdc};

    slcd_engine u_dut (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_sck(sck),
        .i_si(si), .i_cs_n(cs_n), .i_cmd_data(cd),
        .i_frame_tick(i_frame_tick), .o_busy_n(busy_n), .o_cfg(cfg),
        .o_data_ptr(ptr), .o_disp_latch(lat_o), .o_blink_ram(blk_o));
    slcd_host_model u_host (.i_clk(i_sys_clk), .i_busy_n(busy_n),
        .o_sck(sck), .o_si(si), .o_cs_n(cs_n), .o_cd(cd));

    initial begin
        i_sys_clk = 1'b0;
        forever #10 i_sys_clk = ~i_sys_clk;
    end

    function automatic logic [127:0] flat(input logic [3:0] m [32]);
        logic [127:0] f;
        for (int k = 0; k < 32; k++) f[4*k +: 4] = m[k];
        return f;
    endfunction : flat

    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic close_out;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    task automatic nib(input logic bl, input int op, input logic [3:0] d);
        logic [3:0] o;
        o = bl ? br[p] : dr[p];
        o = (op == 0) ? d : (op == 1) ? (o & d) : (o | d);
        if (bl) br[p] = o;
        else dr[p] = o;
        p++;
    endtask : nib

    task automatic put(input logic [7:0] v, input logic cmd);
        logic [15:0] g;
        int n;
        slcd_note_t e;
        n = 0;
        if (cmd) begin
            casez (v)
            8'b010?????: c.mode = v[4:0];
            8'h30: c.xfer = slcd_pkg::SLCD_XFER_CS;
            8'h31: c.xfer = slcd_pkg::SLCD_XFER_FRAME;
            8'h38: c.xfer = slcd_pkg::SLCD_XFER_HOLD;
            8'b111?????: p = v[4:0];
            8'h20: begin
                dr = '{default: 4'h0};
                p = 5'h00;
            end
            8'hd?: nib(1'b0, 0, v[3:0]);
            8'h9?: nib(1'b0, 1, v[3:0]);
            8'hb?: nib(1'b0, 2, v[3:0]);
            8'h15, 8'h14: c.decoder_on = v[0];
            8'h11, 8'h10: c.display_on = v[0];
            8'h00: begin
                br = '{default: 4'h0};
                p = 5'h00;
            end
            8'hc?: nib(1'b1, 0, v[3:0]);
            8'h8?: nib(1'b1, 1, v[3:0]);
            8'ha?: nib(1'b1, 2, v[3:0]);
            8'h1a, 8'h1b: begin
                c.blink_on = 1'b1;
                c.blink_rate = v[0];
            end
            8'h18: c.blink_on = 1'b0;
            default: ;
            endcase
        end else if (c.decoder_on) begin
            if (v <= 8'h0f && c.mode[1:0] == 2'h3) begin
                g = {8'h00, num2[v[3:0]]};
                n = 2;
            end else if (v <= 8'h0f) begin
                g = {4'h0, num3[v[3:0]]};
                n = 3;
            end
            case (v)
            8'ha0: g = 16'h0000;
            8'ha7: g = 16'h0002;
            8'hb0: g = 16'h47e2;
            8'hc0: g = 16'ha7c0;
            8'hdc: g = 16'h1008;
            default: ;
            endcase
            if (v inside {8'ha0, 8'ha7, 8'hb0, 8'hc0, 8'hdc}) n = 4;
            for (int k = 0; k < n; k++) nib(1'b0, 0, g[4*k +: 4]);
        end
        if (c.xfer == slcd_pkg::SLCD_XFER_CS) lat = flat(dr);
        e = '{p, c, flat(br), lat};
        q.push_back(e);
        u_host.send(v, cmd, 8);
    endtask : put

    task automatic do_reset;
        @(negedge i_sys_clk);
        i_srst = 1'b1;
        repeat (6) @(negedge i_sys_clk);
        i_srst = 1'b0;
        dr = '{default: 4'h0};
        br = '{default: 4'h0};
        p = 5'h00;
        c = '0;
        lat = '0;
        chk({ptr, cfg, busy_n}, 17'h00001);
        chk(blk_o | lat_o, '0);
    endtask : do_reset

    task automatic tick;
        @(negedge i_sys_clk);
        i_frame_tick = 1'b1;
        @(negedge i_sys_clk);
        i_frame_tick = 1'b0;
        repeat (4) @(negedge i_sys_clk);
    endtask : tick

    // results show when busy returns; the latch needs chip select idle
    initial begin
        slcd_note_t e;
        repeat (8) @(posedge i_sys_clk);
        forever begin
            @(posedge busy_n);
            wait (cs_n === 1'b1);
            repeat (5) @(posedge i_sys_clk);
            #1;
            if (q.size() == 0) begin
                chk(32'(q.size()), 32'h1);
            end else begin
                e = q.pop_front();
                chk(ptr, e.p);
                chk(cfg, e.c);
                chk(blk_o, e.b);
                chk(lat_o, e.l);
            end
        end
    end

    initial begin
        #1000000;
        bad_count++;
        close_out();
    end

    initial begin
        // reset rises later so the async link resets see a clean edge
        i_srst = 1'b0;
        i_frame_tick = 1'b0;
        bad_count = 0;
        samples_checked = 0;
        void'($urandom(54587));
        do_reset();
        $display("test reset done");
        foreach (cfgs[i]) put(cfgs[i], 1'b1);
        $display("test config done");
        foreach (ramops[i]) put(ramops[i], 1'b1);
        $display("test ram ops done");
        for (int i = 0; i < 40; i++) begin
            if ($urandom % 5 == 0) put(8'he0 | 8'($urandom % 32), 1'b1);
            put(ops6[$urandom % 6] | 8'($urandom % 16), 1'b1);
        end
        $display("test random done");
        put(8'h15, 1'b1);
        put(8'h43, 1'b1);
        for (int i = 0; i < 16; i++) put(8'(i), 1'b0);
        put(8'h40, 1'b1);
        for (int i = 0; i < 16; i++) put(8'(i), 1'b0);
        put(8'hfe, 1'b1);
        foreach (alnum[i]) put(alnum[i], 1'b0);
        put(8'h14, 1'b1);
        put(8'h08, 1'b0);
        $display("test decoder done");
        put(8'h31, 1'b1);
        put(8'hd9, 1'b1);
        tick();
        lat = flat(dr);
        chk(lat_o, lat);
        put(8'h38, 1'b1);
        put(8'hd4, 1'b1);
        tick();
        chk(lat_o, lat);
        put(8'h30, 1'b1);
        $display("test transfer done");
        u_host.send(8'hd3, 1'b1, 5);
        put(8'hd1, 1'b1);
        do_reset();
        put(8'hc7, 1'b1);
        $display("test abort and reset done");
        repeat (20) @(posedge i_sys_clk);
        chk(32'(q.size()), 32'h0);
        close_out();
    end
endmodule : slcd_engine_tb_top

bind slcd_engine slcd_engine_checker #(.DEPTH(DEPTH), .AW(AW)) u_chk (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_cs_n(i_cs_n),
    .i_frame_tick(i_frame_tick), .o_busy_n(o_busy_n), .o_cfg(o_cfg),
    .o_data_ptr(o_data_ptr), .o_disp_latch(o_disp_latch),
    .o_blink_ram(o_blink_ram));
`default_nettype wire

// ---- tb/slcd_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module slcd_host_model (
    input wire logic i_clk,
    input wire logic i_busy_n,
    output var logic o_sck,
    output var logic o_si,
    output var logic o_cs_n,
    output var logic o_cd
);
    initial begin
        o_sck = 1'b0;
        o_si = 1'b0;
        o_cs_n = 1'b1;
        o_cd = 1'b0;
    end
    // nb below 8 aborts the byte by raising chip select early
    task automatic send(input logic [7:0] b, input logic cd, input int nb);
        int i;
        @(negedge i_clk);
        o_cs_n = 1'b0;
        o_cd = cd;
        #2.7;
        for (i = 0; i < nb; i++) begin
            o_si = b[7-i];
            #3 o_sck = 1'b1;
            #3 o_sck = 1'b0;
        end
        // no stale bit left on the line after the frame
        o_si = ~o_si;
        repeat (12) @(negedge i_clk);
        o_cs_n = 1'b1;
        o_cd = ~cd;
        i = 0;
        while (i_busy_n !== 1'b1 && i < 50) begin
            @(negedge i_clk);
            i++;
        end
        repeat (8) @(negedge i_clk);
    endtask : send
endmodule : slcd_host_model
`default_nettype wire
